/* mhu_defines.svh */
// constants for the midi host command uart
`ifndef MHU_DEFINES_SVH
`define MHU_DEFINES_SVH
`define MHU_CMD_RESET     8'hFF
`define MHU_CMD_PASS      8'h3F
`define MHU_ACK_BYTE      8'hFE
`define MHU_STATUS_RESET  8'h80
`define MHU_BIT_EMPTY     7
`define MHU_BIT_BUSY      6
`define MHU_CFG_ACTIVATE  8'h30
`define MHU_CFG_BASE_HI   8'h60
`define MHU_CFG_BASE_LO   8'h61
`define MHU_BASE_RESET    16'h0330
`define MHU_CLK_HZ        50000000
`define MHU_BAUD          31250
`define MHU_BIT_CYCLES    (`MHU_CLK_HZ / `MHU_BAUD)
`define MHU_FRAME_BITS    10
`define MHU_FIFO_DEPTH    16
`endif

/* mhu_midi_peer.sv */
// behavioural midi instrument on the far side of the serial link
`timescale 1ns/100ps
module mhu_midi_peer #(
    parameter int BIT_CYCLES = 16
) (
    input  wire logic clk_i,   // bench clock
    input  wire logic line_i,  // line driven by the uart
    output logic      line_o   // line into the uart
);
    logic [7:0] rx_q[$];
    int         bad_stop = 0;

    // loop line rests at mark level between frames
    initial line_o = 1'b1;

    // ----------------------------------------
    // receiver: samples in the middle of each bit
    // ----------------------------------------
    initial
    begin
        logic [7:0] b;
        forever
        begin
            @(negedge line_i);
            repeat (BIT_CYCLES / 2) @(posedge clk_i);
            if (line_i === 1'b0)
            begin
                for (int i = 0; i < 8; i++)
                begin
                    repeat (BIT_CYCLES) @(posedge clk_i);
                    b[i] = line_i;
                end
                repeat (BIT_CYCLES) @(posedge clk_i);
                if (line_i !== 1'b1)
                    bad_stop++;
                else
                    rx_q.push_back(b);
            end
        end
    end

    // ----------------------------------------
    // sender: start, eight data bits, stop
    // ----------------------------------------
    task automatic send(input logic [7:0] b);
        @(posedge clk_i);
        line_o <= 1'b0;
        repeat (BIT_CYCLES) @(posedge clk_i);
        for (int i = 0; i < 8; i++)
        begin
            line_o <= b[i];
            repeat (BIT_CYCLES) @(posedge clk_i);
        end
        line_o <= 1'b1;
        repeat (BIT_CYCLES) @(posedge clk_i);
    endtask
endmodule

/* mhu_midi_uart.sv */
// midi host interface: command decoder, data port, fifos and serial engines
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/100ps
`include "mhu_defines.svh"
module mhu_midi_uart #(
    parameter int FIFO_DEPTH = `MHU_FIFO_DEPTH,
    parameter int BIT_CYCLES = `MHU_BIT_CYCLES
) (
    input  wire logic        clk_i,                     // 50 MHz clock
    input  wire logic        rstn_i,                    // async reset, low
    input  wire logic [15:0] addr_i,                    // host i/o address
    input  wire logic [7:0]  wdata_i,                   // host write data
    input  wire logic        wr_i,                      // host write strobe
    input  wire logic        host_data_read_strobe_i,   // host read strobe
    output logic      [7:0]  rdata_o,                   // host read data
    input  wire logic [7:0]  cfg_addr_i,                // config index
    input  wire logic [7:0]  cfg_wdata_i,               // config write data
    input  wire logic        cfg_wr_i,                  // config write strobe
    input  wire logic        cfg_rd_i,                  // config read strobe
    output logic      [7:0]  cfg_rdata_o,               // config read data
    input  wire logic        midi_serial_input_i,       // serial line in
    output logic             midi_serial_output_o,      // serial line out
    output logic             irq_o                      // interrupt, high
);
    import mhu_pkg::*;

    localparam int AW = $clog2(FIFO_DEPTH);
    localparam int TW = $clog2(BIT_CYCLES);
    localparam logic [TW-1:0] BIT_LAST = TW'(BIT_CYCLES - 1);
    localparam logic [TW-1:0] HALF_BIT = TW'(BIT_CYCLES / 2 - 1);
    localparam logic [AW:0]   FULL_CNT = (AW+1)'(FIFO_DEPTH);

    initial
    begin
        if (FIFO_DEPTH < 2 || (1 << AW) != FIFO_DEPTH)
            $error("FIFO_DEPTH must be a power of two, at least 2");
        if (BIT_CYCLES < 4)
            $error("BIT_CYCLES must be at least 4");
    end

    // ------------------------------------------------------------
    // configuration space
    // ------------------------------------------------------------
    logic        active_q;
    logic [7:0]  base_hi_q;
    logic [7:0]  base_lo_q;

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            active_q  <= 1'b0;
            base_hi_q <= 8'(`MHU_BASE_RESET >> 8);
            base_lo_q <= 8'(`MHU_BASE_RESET & 16'h00FF);
        end
        else if (cfg_wr_i)
        begin
            unique case (cfg_addr_i)
                `MHU_CFG_ACTIVATE: active_q  <= cfg_wdata_i[0];
                `MHU_CFG_BASE_HI:  base_hi_q <= cfg_wdata_i;
                `MHU_CFG_BASE_LO:  base_lo_q <= cfg_wdata_i;
                default:           active_q  <= active_q;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            cfg_rdata_o <= 8'h00;
        else if (cfg_rd_i)
        begin
            unique case (cfg_addr_i)
                `MHU_CFG_ACTIVATE: cfg_rdata_o <= {7'h00, active_q};
                `MHU_CFG_BASE_HI:  cfg_rdata_o <= base_hi_q;
                `MHU_CFG_BASE_LO:  cfg_rdata_o <= base_lo_q;
                default:           cfg_rdata_o <= 8'h00;
            endcase
        end
        else
            cfg_rdata_o <= 8'h00;
    end

    // ------------------------------------------------------------
    // address decode and command decode
    // ------------------------------------------------------------
    // bit 0 of the base is ignored, so an odd base still decodes a pair
    logic hit;
    logic data_wr, data_rd, cmd_wr, stat_rd;
    logic cmd_reset, cmd_pass;
    logic pass_q;
    logic ack_q;

    assign hit = active_q && (addr_i[15:1] == {base_hi_q, base_lo_q[7:1]});
    assign data_wr = hit && wr_i && !addr_i[0];
    assign data_rd = hit && host_data_read_strobe_i && !addr_i[0];
    assign cmd_wr  = hit && wr_i && addr_i[0];
    assign stat_rd = hit && host_data_read_strobe_i && addr_i[0];
    assign cmd_reset = cmd_wr && (wdata_i == `MHU_CMD_RESET);
    assign cmd_pass  = cmd_wr && (wdata_i == `MHU_CMD_PASS) && !pass_q;

    // power-on reset clears pass_q as the reset command does, but raises no acknowledge
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            pass_q <= 1'b0;
        else if (cmd_reset)
            pass_q <= 1'b0;
        else if (cmd_pass)
            pass_q <= 1'b1;
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            ack_q <= 1'b0;
        else if ((cmd_reset && !pass_q) || cmd_pass)
            ack_q <= 1'b1;
        else if (cmd_reset)
            ack_q <= 1'b0;
        else if (data_rd)
            ack_q <= 1'b0;
    end

    logic flush_rx, flush_tx, run;
    assign flush_rx = cmd_reset || cmd_pass;
    assign flush_tx = cmd_reset || cmd_pass;
    // engines idle outside pass-through or while deactivated
    assign run = pass_q && active_q;

    // ------------------------------------------------------------
    // fifos
    // ------------------------------------------------------------
    logic [7:0]  rx_mem [FIFO_DEPTH];
    logic [7:0]  tx_mem [FIFO_DEPTH];
    logic [AW-1:0] rx_wp_q, rx_rp_q, tx_wp_q, tx_rp_q;
    logic [AW:0]   rx_cnt_q, tx_cnt_q;
    logic        rx_done_q;
    logic [7:0]  rx_sh_q;
    logic        rx_push, rx_pop, tx_push, tx_pop;
    logic [3:0]  tx_left_q;

    assign rx_push = rx_done_q && run && (rx_cnt_q != FULL_CNT);
    assign rx_pop  = data_rd && !ack_q && (rx_cnt_q != '0);
    assign tx_push = data_wr && pass_q && (tx_cnt_q != FULL_CNT);
    assign tx_pop  = run && (tx_left_q == 4'h0) && (tx_cnt_q != '0);

    always_ff @(posedge clk_i)
    begin
        if (rx_push)
            rx_mem[rx_wp_q] <= rx_sh_q;
        if (tx_push)
            tx_mem[tx_wp_q] <= wdata_i;
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rx_wp_q  <= '0;
            rx_rp_q  <= '0;
            rx_cnt_q <= '0;
        end
        else if (flush_rx)
        begin
            rx_wp_q  <= '0;
            rx_rp_q  <= '0;
            rx_cnt_q <= '0;
        end
        else
        begin
            if (rx_push)
                rx_wp_q <= AW'(rx_wp_q + 1'b1);
            if (rx_pop)
                rx_rp_q <= AW'(rx_rp_q + 1'b1);
            unique case ({rx_push, rx_pop})
                2'b10:   rx_cnt_q <= (AW+1)'(rx_cnt_q + 1'b1);
                2'b01:   rx_cnt_q <= (AW+1)'(rx_cnt_q - 1'b1);
                default: rx_cnt_q <= rx_cnt_q;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            tx_wp_q  <= '0;
            tx_rp_q  <= '0;
            tx_cnt_q <= '0;
        end
        else if (flush_tx)
        begin
            tx_wp_q  <= '0;
            tx_rp_q  <= '0;
            tx_cnt_q <= '0;
        end
        else
        begin
            if (tx_push)
                tx_wp_q <= AW'(tx_wp_q + 1'b1);
            if (tx_pop)
                tx_rp_q <= AW'(tx_rp_q + 1'b1);
            unique case ({tx_push, tx_pop})
                2'b10:   tx_cnt_q <= (AW+1)'(tx_cnt_q + 1'b1);
                2'b01:   tx_cnt_q <= (AW+1)'(tx_cnt_q - 1'b1);
                default: tx_cnt_q <= tx_cnt_q;
            endcase
        end
    end

    // ------------------------------------------------------------
    // host read data and interrupt
    // ------------------------------------------------------------
    logic pending;
    assign pending = ack_q || (rx_cnt_q != '0);

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            rdata_o <= 8'h00;
        else if (data_rd && ack_q)
            rdata_o <= `MHU_ACK_BYTE;
        else if (rx_pop)
            rdata_o <= rx_mem[rx_rp_q];
        else if (stat_rd)
        begin
            rdata_o <= 8'h00;
            rdata_o[`MHU_BIT_EMPTY] <= !pending;
            rdata_o[`MHU_BIT_BUSY]  <= (tx_cnt_q == FULL_CNT);
        end
        else
            rdata_o <= 8'h00;
    end

    // registered, so the pop of the last byte drops it one edge later
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            irq_o <= 1'b0;
        else
            irq_o <= active_q && pending;
    end

    // ------------------------------------------------------------
    // serial receiver
    // ------------------------------------------------------------
    mhu_rx_state_t rx_st_q;
    logic [TW-1:0] rx_tmr_q;
    logic [2:0]    rx_n_q;
    logic          rx_in_q;

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            rx_in_q <= 1'b1;
        else
            rx_in_q <= midi_serial_input_i;
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rx_st_q   <= MHU_RX_IDLE;
            rx_tmr_q  <= '0;
            rx_n_q    <= 3'h0;
            rx_sh_q   <= 8'h00;
            rx_done_q <= 1'b0;
        end
        else if (!run)
        begin
            rx_st_q   <= MHU_RX_IDLE;
            rx_done_q <= 1'b0;
        end
        else
        begin
            rx_done_q <= 1'b0;
            unique case (rx_st_q)
                MHU_RX_IDLE:
                    if (!rx_in_q)
                    begin
                        rx_st_q  <= MHU_RX_START;
                        rx_tmr_q <= HALF_BIT;
                    end
                MHU_RX_START:
                    if (rx_tmr_q != '0)
                        rx_tmr_q <= TW'(rx_tmr_q - 1'b1);
                    else if (!rx_in_q)
                    begin
                        rx_st_q  <= MHU_RX_DATA;
                        rx_tmr_q <= BIT_LAST;
                        rx_n_q   <= 3'h0;
                    end
                    else
                        rx_st_q <= MHU_RX_IDLE;  // glitch, not a start bit
                MHU_RX_DATA:
                    if (rx_tmr_q != '0)
                        rx_tmr_q <= TW'(rx_tmr_q - 1'b1);
                    else
                    begin
                        rx_sh_q  <= {rx_in_q, rx_sh_q[7:1]};
                        rx_tmr_q <= BIT_LAST;
                        rx_n_q   <= 3'(rx_n_q + 1'b1);
                        if (rx_n_q == 3'h7)
                            rx_st_q <= MHU_RX_STOP;
                    end
                MHU_RX_STOP:
                    if (rx_tmr_q != '0)
                        rx_tmr_q <= TW'(rx_tmr_q - 1'b1);
                    else
                    begin
                        // a low stop bit is a framing error; the byte is dropped
                        rx_done_q <= rx_in_q;
                        rx_st_q   <= MHU_RX_IDLE;
                    end
            endcase
        end
    end

    // ------------------------------------------------------------
    // serial transmitter
    // ------------------------------------------------------------
    logic [9:0]    tx_sh_q;
    logic [TW-1:0] tx_tmr_q;

    // idle line is all ones in the shifter, so bit 0 is the pin itself
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            tx_sh_q   <= 10'h3FF;
            tx_left_q <= 4'h0;
            tx_tmr_q  <= '0;
        end
        else if (!run || flush_tx)
        begin
            tx_sh_q   <= 10'h3FF;
            tx_left_q <= 4'h0;
        end
        else if (tx_pop)
        begin
            tx_sh_q   <= {1'b1, tx_mem[tx_rp_q], 1'b0};
            tx_left_q <= 4'(`MHU_FRAME_BITS);
            tx_tmr_q  <= BIT_LAST;
        end
        else if (tx_left_q != 4'h0)
        begin
            if (tx_tmr_q != '0)
                tx_tmr_q <= TW'(tx_tmr_q - 1'b1);
            else
            begin
                tx_sh_q   <= {1'b1, tx_sh_q[9:1]};
                tx_left_q <= 4'(tx_left_q - 1'b1);
                tx_tmr_q  <= BIT_LAST;
            end
        end
    end

    assign midi_serial_output_o = tx_sh_q[0];

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    AST_OTHER_CMD: assert property (
        cmd_wr && wdata_i != `MHU_CMD_RESET && wdata_i != `MHU_CMD_PASS
        |=> $stable(pass_q) && $stable(ack_q))
        else $error("unknown command changed state");
    AST_RESET_CMD: assert property (
        cmd_reset |=> !pass_q && rx_cnt_q == '0 && tx_left_q == 4'h0)
        else $error("reset command did not reset");
    AST_RESET_ACK: assert property (
        cmd_reset && !pass_q |=> ack_q ##1 (ack_q || $past(data_rd)))
        else $error("reset command not acknowledged");
    AST_RESET_NOACK: assert property (
        cmd_reset && pass_q |=> !ack_q)
        else $error("reset in pass-through acknowledged");
    AST_DISCARD: assert property (
        !pass_q |=> tx_cnt_q == '0 && rx_cnt_q == '0)
        else $error("bytes kept in reset state");
    AST_PASS_CMD: assert property (
        cmd_pass |=> pass_q && ack_q && rx_cnt_q == '0 && tx_cnt_q == '0)
        else $error("pass-through command incomplete");
    AST_PASS_AGAIN: assert property (
        cmd_wr && wdata_i == `MHU_CMD_PASS && pass_q |=> pass_q && $stable(ack_q))
        else $error("repeated pass-through command acted");
    AST_ACK_FIRST: assert property (
        data_rd && ack_q |=> rdata_o == `MHU_ACK_BYTE)
        else $error("acknowledge not read first");
    AST_STATUS: assert property (
        stat_rd |=> rdata_o[5:0] == 6'h00 && rdata_o[`MHU_BIT_EMPTY] == !$past(pending))
        else $error("status byte wrong");
    AST_IRQ: assert property (
        !active_q ##1 !active_q |-> !irq_o)
        else $error("interrupt while deactivated");
    AST_TX_START: assert property (
        tx_pop |=> !midi_serial_output_o [*8])
        else $error("start bit too short");

    COV_PASS: cover property (cmd_pass ##1 data_rd);
    COV_RX: cover property (rx_push ##[1:200] rx_pop);
    COV_TX: cover property (tx_push ##1 tx_pop);
endmodule

/* mhu_pkg.sv */
// types of the midi host command uart
package mhu_pkg;
    typedef enum logic [1:0] {
        MHU_RX_IDLE  = 2'b00,
        MHU_RX_START = 2'b01,
        MHU_RX_DATA  = 2'b10,
        MHU_RX_STOP  = 2'b11
    } mhu_rx_state_t;
endpackage

/* tb.sv */
// self-checking bench for the midi host command uart
`timescale 1ns/100ps
module tb;
    import mhu_pkg::*;
    localparam int          BIT  = 16;
    localparam logic [15:0] BASE = 16'h0340;

    logic        clk_i   = 1'b0;
    logic        rstn_i  = 1'b0;
    logic [15:0] addr_i;
    logic [7:0]  wdata_i;
    logic        wr_i;
    logic        rd_i;
    logic [7:0]  rdata_o;
    logic [7:0]  cfg_addr_i;
    logic [7:0]  cfg_wdata_i;
    logic        cfg_wr_i;
    logic        cfg_rd_i;
    logic [7:0]  cfg_rdata_o;
    logic        ser_in;
    logic        ser_out;
    logic        irq_o;
    int          num_errors  = 0;
    int          check_count = 0;
    int          cycles      = 0;

    always #10 clk_i = ~clk_i;

    mhu_midi_uart #(.BIT_CYCLES(BIT)) dut (
        .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .host_data_read_strobe_i(rd_i), .rdata_o(rdata_o), .cfg_addr_i(cfg_addr_i),
        .cfg_wdata_i(cfg_wdata_i), .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i),
        .cfg_rdata_o(cfg_rdata_o), .midi_serial_input_i(ser_in),
        .midi_serial_output_o(ser_out), .irq_o(irq_o)
    );
    mhu_midi_peer #(.BIT_CYCLES(BIT)) peer (.clk_i(clk_i), .line_i(ser_out), .line_o(ser_in));

    // ----------------------------------------
    // checks and bus tasks
    // ----------------------------------------
    task automatic summarize();
        if (num_errors == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    // irq is sampled mid-cycle so the edge's updates have landed
    task automatic chk_irq(input string what, input logic exp);
        @(negedge clk_i);
        check_count++;
        if (irq_o !== exp)
        begin
            num_errors++;
            $display("unexpected %s: expected %b seen %b", what, exp, irq_o);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic host_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask

    task automatic host_rd(input logic [15:0] a, input logic [7:0] exp, input string what);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1 chk(what, exp, rdata_o);
    endtask

    task automatic cfg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cfg_addr_i  <= a;
        cfg_wdata_i <= d;
        cfg_wr_i    <= 1'b1;
        @(posedge clk_i);
        cfg_wr_i    <= 1'b0;
    endtask

    task automatic cfg_rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge clk_i);
        cfg_addr_i <= a;
        cfg_rd_i   <= 1'b1;
        @(posedge clk_i);
        cfg_rd_i   <= 1'b0;
        #1 chk(what, exp, cfg_rdata_o);
    endtask

    // hang guard: the whole sequence needs well under 8000 cycles
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            summarize();
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        addr_i      <= 16'h0000;
        wdata_i     <= 8'h00;
        wr_i        <= 1'b0;
        rd_i        <= 1'b0;
        cfg_addr_i  <= 8'h00;
        cfg_wdata_i <= 8'h00;
        cfg_wr_i    <= 1'b0;
        cfg_rd_i    <= 1'b0;
        wait_cyc(2);
        rstn_i <= 1'b1;
        cfg_rd(8'h30, 8'h00, "activate reset");
        cfg_rd(8'h60, 8'h03, "base high");
        cfg_rd(8'h61, 8'h30, "base low");
        cfg_rd(8'h10, 8'h00, "unmapped config");
        host_rd(16'h0331, 8'h00, "status while inactive");
        cfg_wr(8'h61, 8'h40);
        cfg_wr(8'h30, 8'h01);
        host_rd(16'h0331, 8'h00, "old base");
        host_rd(BASE + 16'h0001, 8'h80, "status after reset");
        host_wr(BASE, 8'h5A);
        peer.send(8'h77);
        host_wr(BASE + 16'h0001, 8'h55);
        host_rd(BASE + 16'h0001, 8'h80, "status after unknown");
        host_wr(BASE + 16'h0001, 8'hFF);
        host_rd(BASE + 16'h0001, 8'h00, "status ack pending");
        chk_irq("irq on ack", 1'b1);
        host_rd(BASE, 8'hFE, "reset ack");
        wait_cyc(2);
        chk_irq("irq after read", 1'b0);
        host_wr(BASE + 16'h0001, 8'h3F);
        host_rd(BASE, 8'hFE, "pass ack");
        host_rd(BASE, 8'h00, "empty data read");
        peer.send(8'hA5);
        wait_cyc(4);
        chk_irq("irq on first byte", 1'b1);
        peer.send(8'h3C);
        host_rd(BASE, 8'hA5, "rx first");
        wait_cyc(2);
        chk_irq("irq with data left", 1'b1);
        host_rd(BASE, 8'h3C, "rx second");
        peer.send(8'h11);
        wait_cyc(4);
        host_wr(BASE + 16'h0001, 8'h3F);
        host_rd(BASE, 8'h11, "data after repeated pass");
        host_rd(BASE + 16'h0001, 8'h80, "no ack on repeat");
        peer.send(8'h22);
        wait_cyc(4);
        host_wr(BASE + 16'h0001, 8'hFF);
        host_rd(BASE + 16'h0001, 8'h80, "flush, no ack");
        host_wr(BASE, 8'h99);
        peer.send(8'h44);
        host_rd(BASE + 16'h0001, 8'h80, "rx off after reset");
        host_wr(BASE + 16'h0001, 8'h3F);
        host_rd(BASE, 8'hFE, "pass ack again");
        host_rd(BASE + 16'h0001, 8'h80, "ready before burst");
        for (int i = 0; i < 18; i++)
            host_wr(BASE, 8'h80 + 8'(i));
        host_rd(BASE + 16'h0001, 8'hC0, "status tx full");
        peer.send(8'h5C);
        host_rd(BASE, 8'h5C, "rx during tx");
        for (int n = 0; n < 4000 && peer.rx_q.size() < 17; n++)
            @(posedge clk_i);
        wait_cyc(2 * BIT);
        chk("tx frame count", 8'd17, 8'(peer.rx_q.size()));
        chk("bad stop bits", 8'h00, 8'(peer.bad_stop));
        for (int i = 0; i < 17 && i < peer.rx_q.size(); i++)
            chk("tx byte", 8'h80 + 8'(i), peer.rx_q[i]);
        host_wr(BASE + 16'h0001, 8'hFF);
        host_wr(BASE + 16'h0001, 8'h3F);
        wait_cyc(1);
        chk_irq("irq before deactivate", 1'b1);
        cfg_wr(8'h30, 8'h00);
        wait_cyc(2);
        chk_irq("irq inactive", 1'b0);
        host_rd(BASE, 8'h00, "data while inactive");
        cfg_wr(8'h30, 8'h01);
        wait_cyc(2);
        chk_irq("irq reactivated", 1'b1);
        host_rd(BASE, 8'hFE, "ack kept");
        // second reset while in pass-through: must land as after power-on
        wait_cyc(1);
        rstn_i <= 1'b0;
        wait_cyc(2);
        rstn_i <= 1'b1;
        cfg_rd(8'h30, 8'h00, "activate after reset pulse");
        cfg_wr(8'h30, 8'h01);
        host_rd(16'h0331, 8'h80, "status after reset pulse");
        host_wr(16'h0331, 8'h3F);
        host_rd(16'h0330, 8'hFE, "mode left by reset pulse");
        summarize();
    end
endmodule
